// [rtl/astrx_pkg.sv]
// Purpose: constants and types for the async serial transceiver core
// Assumes: 32-bit avalon-mm slave, one word per register
// Notes: byte addresses below are aligned words
package astrx_pkg;
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFS_STATUS = 5'h00;
  localparam logic [4:0] OFS_DATA = 5'h04;
  localparam logic [4:0] OFS_CTRL1 = 5'h08;
  localparam logic [4:0] OFS_CTRL2 = 5'h0C;
  localparam logic [4:0] OFS_RATE = 5'h10;
  localparam logic [4:0] OFS_RX_FINE = 5'h14;
  localparam logic [4:0] OFS_TX_FINE = 5'h18;
  // ctrl1 fields
  localparam int C1_RX_NINTH = 7;
  localparam int C1_TX_NINTH = 6;
  localparam int C1_WORD9 = 4;
  localparam int C1_WAKE_ADDR = 3;
  // ctrl2 fields
  localparam int C2_TX_EMPTY_IE = 7;
  localparam int C2_TX_DONE_IE = 6;
  localparam int C2_RX_IE = 5;
  localparam int C2_IDLE_IE = 4;
  localparam int C2_TX_ON = 3;
  localparam int C2_RX_ON = 2;
  localparam int C2_MUTE = 1;
  localparam int C2_BREAK = 0;
  // rate divider fields
  localparam int RT_PS_HI = 7;
  localparam int RT_PS_LO = 6;
  localparam int RT_TX_HI = 5;
  localparam int RT_TX_LO = 3;
  localparam int RT_RX_HI = 2;
  localparam int RT_RX_LO = 0;
  // reset values
  localparam logic [7:0] RST_CTRL1 = 8'h00;
  localparam logic [7:0] RST_CTRL2 = 8'h00;
  localparam logic [7:0] RST_RATE = 8'h00;
  localparam logic [7:0] RST_FINE = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'hC0;
  // timing: 16 samples per bit, conventional divider 32 = 16 * 2
  localparam logic [11:0] PRE_1 = 12'h002;
  localparam logic [11:0] PRE_3 = 12'h006;
  localparam logic [11:0] PRE_4 = 12'h008;
  localparam logic [11:0] PRE_13 = 12'h01A;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] VOTE_A = 4'h7;
  localparam logic [3:0] VOTE_B = 4'h8;
  localparam logic [3:0] VOTE_C = 4'h9;
  localparam logic [3:0] LEN_8 = 4'hA;
  localparam logic [3:0] LEN_9 = 4'hB;
  localparam logic [7:0] IDLE_TICKS_8 = 8'h9F;
  localparam logic [7:0] IDLE_TICKS_9 = 8'hAF;
  typedef enum logic [1:0] {K_DATA, K_IDLE, K_BRK, K_MARK} astrx_kind_t;
  typedef enum logic {TX_WAIT, TX_SEND} astrx_txst_t;
  typedef enum logic {RX_HUNT, RX_RECV} astrx_rxst_t;
endpackage : astrx_pkg

// [rtl/astrx_core.sv]
// Purpose: full duplex async nrz serial transceiver with avalon-mm slave
// Assumes: clk 125 MHz, srst synchronous active high, serial_in async
// Notes: halt freezes both engines; registers still answer the bus
`timescale 1ns/10ps
// Notes on behaviour
// RQ1: status access then data write clears tx flags
// RQ2: send break loads break frame, word-length sized
// RQ3: breaks repeat; one mark bit after last
// RQ4: transmitter enable sends one idle frame first
// RQ5: enable toggle queues idle, drops buffered byte
// RQ6: receive lsb first, ninth bit to ctrl1
// RQ7: receiver enable starts hunting for start bit
// RQ8: completed char moves to buffer, sets full
// RQ9: status access then data read clears full
// RQ10: received break counts as framing error
// RQ11: idle frame sets idle flag, own interrupt
// RQ12: full still set gives overrun, buffer kept
// RQ13: overrun cleared by status then data read
// RQ14: noise flag rises with full, data kept
// RQ15: missing stop bit or break sets framing
// RQ16: conventional rate clk/(32*prescale*power-of-two)
// RQ17: software leaves rate alone while enabled
// RQ18: nonzero fine prescaler gives clk/(16*value)
// RQ19: mute blocks all receive flags and interrupts
// RQ20: idle wake clears mute, idle flag stays
// RQ21: address mark clears mute, word received
// RQ22: halt freezes engines; events wake wait only
// RQ23: start bit low, stop high, idle high
// RQ24: word bit selects eight or nine data
// RQ25: 16x sampling, majority vote, noise on disagree
module astrx_core
  import astrx_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_active,
  input wire logic global_mask,
  input wire logic halt_mode,
  output logic irq_req,
  output logic wait_wake
);
  // register state
  logic [7:0] ctrl1;
  logic [7:0] ctrl2;
  logic [7:0] rate_divider_reg;
  logic [7:0] rx_fine_prescaler;
  logic [7:0] tx_fine_prescaler;
  logic [7:0] tx_buffer;
  logic [7:0] rx_buffer;
  logic rx_ninth_bit;
  logic tx_buffer_empty_flag, tx_done_flag, rx_full_flag, idle_flag;
  logic overrun_flag, noise_flag, framing_error_flag;
  logic status_seen, ack, tx_on_q, brk_req;
  // bus decode
  wire req = (avs_read | avs_write) & ~ack;
  wire acc = (avs_read | avs_write) & ack;
  wire wr_acc = acc & avs_write;
  wire rd_acc = acc & avs_read;
  wire sel_status = avs_address == OFS_STATUS;
  wire sel_data = avs_address == OFS_DATA;
  wire sel_ctrl1 = avs_address == OFS_CTRL1;
  wire sel_ctrl2 = avs_address == OFS_CTRL2;
  wire sel_rate = avs_address == OFS_RATE;
  wire sel_rxf = avs_address == OFS_RX_FINE;
  wire sel_txf = avs_address == OFS_TX_FINE;
  wire dr_wr = wr_acc & sel_data;
  wire dr_rd = rd_acc & sel_data;
  wire clr_tx = dr_wr & status_seen;
  wire clr_rx = dr_rd & status_seen;
  wire tx_on_bit = ctrl2[C2_TX_ON];
  wire rx_on_bit = ctrl2[C2_RX_ON];
  wire rx_mute_bit = ctrl2[C2_MUTE];
  wire send_break_bit = ctrl2[C2_BREAK];
  wire word9 = ctrl1[C1_WORD9];
  wire run = ~halt_mode;
  wire [7:0] status_reg = {tx_buffer_empty_flag, tx_done_flag, rx_full_flag,
    idle_flag, overrun_flag, noise_flag, framing_error_flag, 1'b0};
  wire [7:0] ctrl1_view = {rx_ninth_bit, ctrl1[6:0]};
  wire [7:0] rd_mux = sel_status ? status_reg :
    sel_data ? rx_buffer :
    sel_ctrl1 ? ctrl1_view :
    sel_ctrl2 ? ctrl2 :
    sel_rate ? rate_divider_reg :
    sel_rxf ? rx_fine_prescaler :
    sel_txf ? tx_fine_prescaler : 8'h00;
  assign avs_waitrequest = req;

  always_ff @(posedge clk) begin
    if (srst) begin
      ack <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack <= req;
      if (req) begin
        avs_readdata <= {24'h00_0000, rd_mux};
      end
    end
  end

  // rate generators, index 0 transmit, 1 receive
  function automatic logic [11:0] astrx_period(input logic [1:0] ps,
      input logic [2:0] dv, input logic [7:0] fine);
    logic [11:0] base;
    case (ps)
      2'h0: base = PRE_1;
      2'h1: base = PRE_3;
      2'h2: base = PRE_4;
      default: base = PRE_13;
    endcase
    if (fine != 8'h00) begin
      return {4'h0, fine}; // RQ18
    end
    return base << dv; // RQ16
  endfunction : astrx_period

  wire [11:0] period [2];
  logic [11:0] bcnt [2];
  wire tick [2];
  assign period[0] = astrx_period(rate_divider_reg[RT_PS_HI:RT_PS_LO],
    rate_divider_reg[RT_TX_HI:RT_TX_LO], tx_fine_prescaler);
  assign period[1] = astrx_period(rate_divider_reg[RT_PS_HI:RT_PS_LO],
    rate_divider_reg[RT_RX_HI:RT_RX_LO], rx_fine_prescaler);
  genvar gd;
  generate
    for (gd = 0; gd < 2; gd++) begin : g_rate
      assign tick[gd] = run & (bcnt[gd] >= period[gd] - 12'h001);
      always_ff @(posedge clk) begin
        if (srst) begin
          bcnt[gd] <= 12'h000;
        end else if (run) begin
          bcnt[gd] <= tick[gd] ? 12'h000 : bcnt[gd] + 12'h001; // RQ22
        end
      end
    end
  endgenerate

  // transmitter
  astrx_txst_t tx_state;
  astrx_kind_t tx_kind;
  logic [10:0] tx_frame;
  logic [3:0] tx_bit, tx_sub, tx_len;
  logic break_trail, idle_pending;
  wire want_brk = send_break_bit | brk_req;
  wire tx_idle = tx_state == TX_WAIT;
  wire tx_toggle = tx_on_bit & ~tx_on_q;
  // no start while an enable edge is queueing its idle frame
  wire tx_start = tx_idle & run & tx_on_bit & ~tx_toggle &
    (break_trail | want_brk | idle_pending | ~tx_buffer_empty_flag);
  wire tx_load = tx_start & ~break_trail & ~want_brk & ~idle_pending;
  wire tx_end = ~tx_idle & tick[0] & (tx_sub == OVS_LAST) &
    (tx_bit == tx_len - 4'h1);
  wire [3:0] frame_len = word9 ? LEN_9 : LEN_8; // RQ24
  wire stop_or_ninth = word9 ? ctrl1[C1_TX_NINTH] : 1'b1;

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_state <= TX_WAIT;
      tx_kind <= K_IDLE;
      tx_frame <= 11'h7FF;
      tx_bit <= 4'h0;
      tx_sub <= 4'h0;
      tx_len <= LEN_8;
    end else begin
      case (tx_state)
        TX_WAIT: begin
          tx_bit <= 4'h0;
          tx_sub <= 4'h0;
          if (tx_start) begin
            tx_state <= TX_SEND;
            if (break_trail) begin
              tx_kind <= K_MARK; // RQ3
              tx_frame <= 11'h7FF;
              tx_len <= 4'h1;
            end else if (want_brk) begin
              tx_kind <= K_BRK; // RQ2
              tx_frame <= 11'h000;
              tx_len <= frame_len;
            end else if (idle_pending) begin
              tx_kind <= K_IDLE; // RQ4
              tx_frame <= 11'h7FF;
              tx_len <= frame_len;
            end else begin
              tx_kind <= K_DATA; // RQ23
              tx_frame <= {1'b1, stop_or_ninth, tx_buffer, 1'b0};
              tx_len <= frame_len;
            end
          end
        end
        TX_SEND: begin
          if (tick[0]) begin
            tx_sub <= tx_sub + 4'h1;
            if (tx_sub == OVS_LAST) begin
              tx_bit <= tx_bit + 4'h1;
              tx_frame <= {1'b1, tx_frame[10:1]};
            end
            if (tx_end) begin
              tx_state <= TX_WAIT;
            end
          end
        end
        default: tx_state <= TX_WAIT;
      endcase
    end
  end
  assign serial_out_pin = tx_idle ? 1'b1 : tx_frame[0]; // RQ23
  assign serial_out_active = tx_on_bit | ~tx_idle;

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_on_q <= 1'b0;
      break_trail <= 1'b0;
      idle_pending <= 1'b0;
      brk_req <= 1'b0;
    end else begin
      tx_on_q <= tx_on_bit;
      if (tx_end && tx_kind == K_BRK && !send_break_bit) begin
        break_trail <= 1'b1; // RQ3
      end else if (tx_start && break_trail) begin
        break_trail <= 1'b0;
      end
      if (tx_toggle) begin
        idle_pending <= 1'b1; // RQ5
      end else if (tx_start && !break_trail && !want_brk) begin
        idle_pending <= 1'b0;
      end
      if (wr_acc && sel_ctrl2 && avs_writedata[C2_BREAK]) begin
        brk_req <= 1'b1;
      end else if (tx_start && !break_trail) begin
        brk_req <= 1'b0;
      end
    end
  end

  // receiver
  logic sin_s1, sin_s2, vote_a, vote_b, rx_noise;
  astrx_rxst_t rx_state;
  logic [3:0] rx_bit, rx_sub;
  logic [8:0] rx_shift;
  logic [7:0] idle_cnt;
  logic idle_hold, idle_armed;
  wire rx_busy = rx_state == RX_RECV;
  wire samp = rx_busy & tick[1] & (rx_sub == VOTE_C);
  wire vote = (vote_a & vote_b) | (vote_a & sin_s2) | (vote_b & sin_s2);
  wire disagree = ~((vote_a == vote_b) & (vote_b == sin_s2)); // RQ25
  wire rx_done = samp & (rx_bit == frame_len - 4'h1);
  wire [8:0] rx_word = word9 ? rx_shift : {1'b0, rx_shift[7:0]};
  wire rx_msb = word9 ? rx_shift[8] : rx_shift[7];
  wire [7:0] idle_lim = word9 ? IDLE_TICKS_9 : IDLE_TICKS_8;
  wire idle_det = tick[1] & rx_on_bit & ~rx_busy & sin_s2 & ~idle_hold &
    (idle_cnt == idle_lim); // RQ11
  wire wake_addr = rx_done & rx_mute_bit & ctrl1[C1_WAKE_ADDR] & rx_msb;
  wire wake_idle = idle_det & rx_mute_bit & ~ctrl1[C1_WAKE_ADDR];
  wire muted = rx_mute_bit & ~wake_addr; // RQ19
  wire rx_store = rx_done & ~muted & ~rx_full_flag; // RQ8
  wire ovr_set = rx_done & ~muted & rx_full_flag; // RQ12
  wire idle_set = idle_det & ~rx_mute_bit & idle_armed; // RQ20
  wire fe_now = ~vote; // RQ15

  always_ff @(posedge clk) begin
    if (srst) begin
      sin_s1 <= 1'b1;
      sin_s2 <= 1'b1;
    end else begin
      sin_s1 <= serial_in_pin;
      sin_s2 <= sin_s1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_state <= RX_HUNT;
      rx_bit <= 4'h0;
      rx_sub <= 4'h0;
      rx_shift <= 9'h000;
      rx_noise <= 1'b0;
      vote_a <= 1'b1;
      vote_b <= 1'b1;
    end else if (tick[1]) begin
      if (rx_sub == VOTE_A) begin
        vote_a <= sin_s2;
      end
      if (rx_sub == VOTE_B) begin
        vote_b <= sin_s2;
      end
      case (rx_state)
        RX_HUNT: begin
          if (rx_on_bit && !sin_s2) begin
            rx_state <= RX_RECV; // RQ7
            rx_sub <= 4'h1;
            rx_bit <= 4'h0;
            rx_noise <= 1'b0;
          end
        end
        RX_RECV: begin
          rx_sub <= rx_sub + 4'h1;
          if (rx_sub == OVS_LAST) begin
            rx_bit <= rx_bit + 4'h1;
          end
          if (samp) begin
            rx_noise <= rx_noise | disagree;
            if (rx_bit == 4'h0 && vote) begin
              rx_state <= RX_HUNT;
            end else if (rx_done) begin
              rx_state <= RX_HUNT;
            end else if (rx_bit != 4'h0) begin
              rx_shift[rx_bit - 4'h1] <= vote; // RQ6
            end
          end
        end
        default: rx_state <= RX_HUNT;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      idle_cnt <= 8'h00;
      idle_hold <= 1'b0;
      idle_armed <= 1'b1;
    end else if (tick[1]) begin
      if (rx_busy || !sin_s2 || !rx_on_bit) begin
        idle_cnt <= 8'h00;
        idle_hold <= 1'b0;
      end else if (idle_det) begin
        idle_hold <= 1'b1;
      end else if (!idle_hold) begin
        idle_cnt <= idle_cnt + 8'h01;
      end
      if (idle_set) begin
        idle_armed <= 1'b0;
      end else if (rx_store) begin
        idle_armed <= 1'b1;
      end
    end
  end

  // software registers and flags
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl1 <= RST_CTRL1;
      ctrl2 <= RST_CTRL2;
      rate_divider_reg <= RST_RATE;
      rx_fine_prescaler <= RST_FINE;
      tx_fine_prescaler <= RST_FINE;
      tx_buffer <= 8'h00;
      status_seen <= 1'b0;
    end else begin
      if (wr_acc && sel_ctrl1) begin
        ctrl1 <= avs_writedata[7:0];
      end
      if (wake_addr || wake_idle) begin
        ctrl2 <= (wr_acc && sel_ctrl2 ? avs_writedata[7:0] : ctrl2) &
          ~(8'h01 << C2_MUTE); // RQ21
      end else if (wr_acc && sel_ctrl2) begin
        ctrl2 <= avs_writedata[7:0];
      end
      if (wr_acc && sel_rate) begin
        rate_divider_reg <= avs_writedata[7:0]; // RQ17
      end
      if (wr_acc && sel_rxf) begin
        rx_fine_prescaler <= avs_writedata[7:0];
      end
      if (wr_acc && sel_txf) begin
        tx_fine_prescaler <= avs_writedata[7:0];
      end
      if (dr_wr) begin
        tx_buffer <= avs_writedata[7:0];
      end
      if (rd_acc && sel_status) begin
        status_seen <= 1'b1;
      end else if (acc && sel_data) begin
        status_seen <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      {tx_buffer_empty_flag, tx_done_flag} <= RST_STATUS[7:6];
      {rx_full_flag, idle_flag, overrun_flag} <= RST_STATUS[5:3];
      {noise_flag, framing_error_flag} <= RST_STATUS[2:1];
      rx_buffer <= 8'h00;
      rx_ninth_bit <= 1'b0;
    end else begin
      tx_buffer_empty_flag <= tx_load | tx_toggle |
        (tx_buffer_empty_flag & ~clr_tx); // RQ1
      tx_done_flag <= tx_end | (tx_done_flag & ~clr_tx); // RQ1
      rx_full_flag <= rx_store | (rx_full_flag & ~clr_rx); // RQ9
      idle_flag <= idle_set | (idle_flag & ~clr_rx);
      overrun_flag <= ovr_set | (overrun_flag & ~clr_rx); // RQ13
      noise_flag <= (rx_store & (rx_noise | disagree)) |
        (noise_flag & ~clr_rx); // RQ14
      framing_error_flag <= (rx_store & fe_now) |
        (framing_error_flag & ~clr_rx); // RQ10
      if (rx_store) begin
        rx_buffer <= rx_word[7:0];
        rx_ninth_bit <= rx_word[8]; // RQ6
      end
    end
  end

  // interrupt request and wait wake
  wire events = (tx_buffer_empty_flag & ctrl2[C2_TX_EMPTY_IE]) |
    (tx_done_flag & ctrl2[C2_TX_DONE_IE]) |
    ((rx_full_flag | overrun_flag) & ctrl2[C2_RX_IE]) |
    (idle_flag & ctrl2[C2_IDLE_IE]);
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_req <= 1'b0;
      wait_wake <= 1'b0;
    end else begin
      irq_req <= events & ~global_mask; // RQ8
      wait_wake <= events & run; // RQ22
    end
  end

  // checks; cycles since an accepted status read, cleared by any other access
  logic [3:0] chk_gap;
  always_ff @(posedge clk) begin
    if (srst) begin
      chk_gap <= 4'h0;
    end else if (rd_acc && sel_status) begin
      chk_gap <= 4'h1;
    end else if (acc) begin
      chk_gap <= 4'h0;
    end else if (chk_gap != 4'h0 && chk_gap != 4'hF) begin
      chk_gap <= chk_gap + 4'h1;
    end
  end
  sequence s_status_then_write;
    chk_gap != 4'h0 && chk_gap <= 4'h9 && dr_wr;
  endsequence
  property p_tx_clear;
    @(posedge clk) disable iff (srst)
    s_status_then_write ##0 (!tx_load && !tx_toggle && !tx_end) |=>
      !tx_buffer_empty_flag && !tx_done_flag;
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("tx flags kept"); // RQ1
  property p_break_load;
    @(posedge clk) disable iff (srst)
    tx_start && !break_trail && send_break_bit |=>
      tx_kind == K_BRK && tx_frame == 11'h000 && tx_len == $past(frame_len);
  endproperty
  a_break_load: assert property (p_break_load) else $error("no break"); // RQ2
  property p_break_trail;
    @(posedge clk) disable iff (srst)
    tx_end && tx_kind == K_BRK && !send_break_bit && tx_on_bit && run
      |=> ##1 tx_kind == K_MARK && serial_out_pin;
  endproperty
  a_break_trail: assert property (p_break_trail) else $error("no mark"); // RQ3
  property p_idle_first;
    @(posedge clk) disable iff (srst)
    tx_toggle && tx_idle && !break_trail && !want_brk && run
      |=> ##1 tx_kind == K_IDLE && !tx_idle;
  endproperty
  a_idle_first: assert property (p_idle_first) else $error("no idle"); // RQ4
  property p_start_low;
    @(posedge clk) disable iff (srst)
    !tx_idle && tx_kind == K_DATA && tx_bit == 4'h0 |-> !serial_out_pin;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start"); // RQ23
  property p_store;
    @(posedge clk) disable iff (srst)
    rx_store |=> rx_full_flag && rx_buffer == $past(rx_word[7:0]);
  endproperty
  a_store: assert property (p_store) else $error("not stored"); // RQ8
  property p_overrun;
    @(posedge clk) disable iff (srst)
    ovr_set |=> overrun_flag && $stable(rx_buffer) && rx_full_flag;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun"); // RQ12
  property p_mute;
    @(posedge clk) disable iff (srst)
    rx_mute_bit && !wake_addr && !clr_rx |=>
      $stable({rx_full_flag, idle_flag, overrun_flag, noise_flag,
      framing_error_flag});
  endproperty
  a_mute: assert property (p_mute) else $error("flag while muted"); // RQ19
  property p_halt;
    @(posedge clk) disable iff (srst)
    halt_mode [*2] |-> $stable(tx_frame) && $stable(rx_shift);
  endproperty
  a_halt: assert property (p_halt) else $error("moved in halt"); // RQ22
endmodule : astrx_core

// [verification/astrx_peer.sv]
// Purpose: far-side serial equipment model for the transceiver
// Assumes: line idles high; receive side set to 16 cycles per bit
// Notes: send and capture are blocking tasks called from the bench
`timescale 1ns/10ps
module astrx_peer (
  input wire logic clk,
  input wire logic serial_out_pin,
  output logic serial_in_pin
);
  initial serial_in_pin = 1'b1;

  // one bit of 16 cycles, optional one-cycle glitch at sample 8
  task automatic drive_bit(input logic v, input logic gl);
    serial_in_pin <= v;
    repeat (8) @(posedge clk);
    if (gl) serial_in_pin <= ~v;
    @(posedge clk);
    serial_in_pin <= v;
    repeat (7) @(posedge clk);
  endtask : drive_bit

  task automatic send(input logic [8:0] d, input int nb, input logic stop,
      input logic gl);
    @(posedge clk);
    drive_bit(1'b0, 1'b0);
    for (int i = 0; i < nb; i++) begin
      drive_bit(d[i], gl && i == 2);
    end
    drive_bit(stop, 1'b0);
    serial_in_pin <= 1'b1;
  endtask : send

  // waits for a start bit, then samples each bit in its middle
  task automatic capture(input int bc, input int nb, output logic [8:0] d,
      output logic stop, output logic ok);
    int n;
    d = '0;
    n = 0;
    while (serial_out_pin !== 1'b0 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    ok = (n < 5000);
    repeat (bc / 2) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      repeat (bc) @(posedge clk);
      d[i] = serial_out_pin;
    end
    repeat (bc) @(posedge clk);
    stop = serial_out_pin;
  endtask : capture
endmodule : astrx_peer

// [verification/tb.sv]
// Purpose: self-checking bench for the async serial transceiver
// Assumes: transmit at reset rate setting, receive fine prescaler 1
// Notes: far-side equipment is modelled by astrx_peer
`timescale 1ns/10ps
module tb;
  import astrx_pkg::*;
  logic clk;
  logic srst;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic serial_in_pin;
  logic serial_out_pin;
  logic global_mask;
  logic halt_mode;
  logic irq_req;
  logic sact;
  logic wake;
  logic [31:0] rd;
  logic [8:0] cd;
  logic cs;
  logic cok;
  int err_count;
  int num_checks;
  int lows;

  astrx_core astrx_core_inst (.clk(clk), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .serial_out_active(sact), .global_mask(global_mask),
    .halt_mode(halt_mode), .irq_req(irq_req), .wait_wake(wake));

  astrx_peer astrx_peer_inst (.clk(clk), .serial_out_pin(serial_out_pin),
    .serial_in_pin(serial_in_pin));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one avalon transfer, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [4:0] a,
      input logic [31:0] wd, output logic [31:0] q);
    q = 32'h00000000;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_read <= ~wr;
    avs_write <= wr;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) begin
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        return;
      end
    end
    err_count++;
    complete_run();
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h000000, d}, rd);
  endtask : wr

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] m,
      input logic [31:0] e);
    bus(1'b0, a, 32'h00000000, rd);
    check(rd & m, e);
  endtask : rd_chk

  task automatic rx_chk(input logic [7:0] s, input logic [7:0] d);
    repeat (4) @(posedge clk);
    rd_chk(OFS_STATUS, 32'h0000002E, {24'h000000, s});
    rd_chk(OFS_DATA, 32'h000000FF, {24'h000000, d});
  endtask : rx_chk

  initial begin
    srst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    global_mask = 1'b0;
    halt_mode = 1'b0;
    err_count = 0;
    num_checks = 0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rd_chk(OFS_STATUS, 32'hFFFFFFFF, 32'h000000C0);
    check(sact, 1'b0);
    rd_chk(OFS_CTRL2, 32'hFFFFFFFF, 32'h00000000);
    rd_chk(5'h1C, 32'hFFFFFFFF, 32'h00000000);
    // transmit: idle frame first, then the byte
    wr(OFS_CTRL2, 8'h08);
    bus(1'b0, OFS_STATUS, 32'h00000000, rd);
    check(sact, 1'b1);
    wr(OFS_DATA, 8'hA5);
    rd_chk(OFS_STATUS, 32'h000000C0, 32'h00000000);
    lows = 0;
    while (serial_out_pin === 1'b1 && lows < 1000) begin
      @(posedge clk);
      lows++;
    end
    check(lows > 250 && lows <= 320, 1'b1);
    astrx_peer_inst.capture(32, 8, cd, cs, cok);
    check({cok, cs, cd}, {2'b11, 9'h0A5});
    wr(OFS_CTRL2, 8'h09);
    astrx_peer_inst.capture(32, 8, cd, cs, cok);
    check({cok, cs, cd}, {2'b10, 9'h000});
    wr(OFS_CTRL2, 8'h08);
    repeat (700) @(posedge clk);
    // halt stretches a frame of nine low bits by the halted time
    bus(1'b0, OFS_STATUS, 32'h00000000, rd);
    wr(OFS_DATA, 8'h00);
    lows = 0;
    while (serial_out_pin === 1'b1 && lows < 1000) begin
      @(posedge clk);
      lows++;
    end
    halt_mode <= 1'b1;
    repeat (100) @(posedge clk);
    check(serial_out_pin, 1'b0);
    halt_mode <= 1'b0;
    lows = 0;
    while (serial_out_pin === 1'b0 && lows < 1000) begin
      @(posedge clk);
      lows++;
    end
    check(lows > 280 && lows < 296, 1'b1);
    wr(OFS_CTRL2, 8'h00);
    // receive at fine prescaler 1
    wr(OFS_RX_FINE, 8'h01);
    wr(OFS_CTRL2, 8'h24);
    astrx_peer_inst.send(9'h03C, 8, 1'b1, 1'b0);
    repeat (4) @(posedge clk);
    check(irq_req, 1'b1);
    global_mask <= 1'b1;
    repeat (3) @(posedge clk);
    check(irq_req, 1'b0);
    check(wake, 1'b1);
    global_mask <= 1'b0;
    rx_chk(8'h20, 8'h3C);
    rd_chk(OFS_STATUS, 32'h0000002E, 32'h00000000);
    check(irq_req, 1'b0);
    astrx_peer_inst.send(9'h011, 8, 1'b1, 1'b0);
    astrx_peer_inst.send(9'h022, 8, 1'b1, 1'b0);
    rx_chk(8'h28, 8'h11);
    rd_chk(OFS_STATUS, 32'h0000002E, 32'h00000000);
    astrx_peer_inst.send(9'h000, 8, 1'b0, 1'b0);
    rx_chk(8'h22, 8'h00);
    astrx_peer_inst.send(9'h05A, 8, 1'b1, 1'b1);
    rx_chk(8'h24, 8'h5A);
    wr(OFS_CTRL1, 8'h10);
    astrx_peer_inst.send(9'h1A5, 9, 1'b1, 1'b0);
    rx_chk(8'h20, 8'hA5);
    rd_chk(OFS_CTRL1, 32'h00000080, 32'h00000080);
    // muted receiver, address-mark wake
    wr(OFS_CTRL1, 8'h08);
    wr(OFS_CTRL2, 8'h26);
    astrx_peer_inst.send(9'h012, 8, 1'b1, 1'b0);
    repeat (4) @(posedge clk);
    check(irq_req, 1'b0);
    rd_chk(OFS_STATUS, 32'h0000002E, 32'h00000000);
    astrx_peer_inst.send(9'h092, 8, 1'b1, 1'b0);
    rx_chk(8'h20, 8'h92);
    rd_chk(OFS_CTRL2, 32'h00000002, 32'h00000000);
    // idle line after a character, then idle-line wake
    repeat (200) @(posedge clk);
    rd_chk(OFS_STATUS, 32'h00000010, 32'h00000010);
    rd_chk(OFS_DATA, 32'h000000FF, 32'h00000092);
    wr(OFS_CTRL1, 8'h00);
    wr(OFS_CTRL2, 8'h26);
    astrx_peer_inst.send(9'h0C3, 8, 1'b1, 1'b0);
    repeat (200) @(posedge clk);
    rd_chk(OFS_CTRL2, 32'h00000002, 32'h00000000);
    rd_chk(OFS_STATUS, 32'h0000003E, 32'h00000000);
    complete_run();
  end
endmodule : tb
